// [shared/adc_ctrl_pkg.sv]
/*
 * Constants, field layouts and carrier types for the queued converter
 * control shell. Assumes one 10 MHz clock and an APB master in front.
 */
// Overview of operation
// R01: Port B is eight input-only bits, sampled when its data register is read.
// R02: Port A bits 4:3 are queue triggers; external trigger mode forces them input.
// R03: Multiplexed mode drives a 3-bit address from each command word channel; the code updates it only for channels below 32.
// R04: Multiplexed mode forces address pins 2:0 to outputs, ignoring direction bits.
// R05: Groups: w even 0-14, x odd 1-15, y even 16-30, z odd 17-31.
// R06: Byte, word and long accesses accepted; each 16-bit word is independent.
// R07: Accesses take two cycles; table conflicts add one to four wait states.
// R08: Unimplemented configuration bits read zero and ignore writes.
// R09: Stop gates the converter clock, aborts conversions, then needs recovery time.
// R10: In stop, global regs stay usable; port regs read-only; control regs reset.
// R11: In stop, tables are inaccessible; divider and periodic timer held reset.
// R12: Freeze happens only when bus freeze and freeze enable are both set.
// R13: Freeze waits for the current conversion unless mode changes or abort.
// R14: Freezing with an active queue saves its command word pointer.
// R15: Freeze holds analog logic reset and unclocked; divider runs; timer reset.
// R16: Freeze ignores external triggers; all registers and tables stay accessible.
// R17: After freeze, next word comes from modes, saved pointer and pending triggers.
// R18: Global registers are supervisor-only; the rest follow the supervisor-select bit.
// R19: User reads of supervisor-only space return zero.
// R20: User reads of supervisor-assigned space return ffff.
// R21: User writes to supervisor-only or supervisor-assigned space are ignored.
// R22: The multiplex-enable bit in control register zero selects multiplexed mode.
// R23: In multiplexed mode port A reads return address latches on bits 2:0.
package adc_ctrl_pkg;
  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int RECOVERY_NS = 10000;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_WAIT = 4;
  localparam int PERIOD_CYCLES = 1000;
  // ********************************
  // Register offsets
  // ********************************
  localparam logic [11:0] MCR_OFF = 12'h000;
  localparam logic [11:0] TEST_OFF = 12'h004;
  localparam logic [11:0] INTR_OFF = 12'h008;
  localparam logic [11:0] PA_OFF = 12'h00c;
  localparam logic [11:0] PB_OFF = 12'h010;
  localparam logic [11:0] DIR_OFF = 12'h014;
  localparam logic [11:0] CR0_OFF = 12'h018;
  localparam logic [11:0] Q1_OFF = 12'h01c;
  localparam logic [11:0] Q2_OFF = 12'h020;
  localparam logic [11:0] STAT_OFF = 12'h024;
  localparam logic [3:0] CCW_PAGE = 4'h1;
  localparam logic [3:0] RES_PAGE = 4'h2;
  localparam int TABLE_WORDS = 40;
  // ********************************
  // Fields and reset values
  // ********************************
  localparam int MCR_STOP_BIT = 15;
  localparam int MCR_FRZ_BIT = 14;
  localparam int MCR_SUPERVISOR_SELECT_BIT_BIT = 7;
  localparam logic [15:0] MCR_MASK = 16'hc08f;
  localparam logic [15:0] MCR_RESET = 16'h0080;
  localparam int CR0_MUX_BIT = 15;
  localparam int CR0_PRESC_LSB = 0;
  localparam logic [15:0] CR0_MASK = 16'h801f;
  localparam int QCR_MODE_LSB = 8;
  localparam int QCR_SWTRIG_BIT = 13;
  localparam int QCR_ABORT_BIT = 12;
  localparam int QCR_BQ2_LSB = 0;
  localparam logic [15:0] Q1_MASK = 16'h0700;
  localparam logic [15:0] Q2_MASK = 16'h073f;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [5:0] END_CHAN = 6'h3f;
  localparam int TRIG1_PIN = 3;
  localparam int TRIG2_PIN = 4;
  localparam int MA_W = 3;

  typedef enum logic [2:0] {
    M_OFF = 3'h0, M_SOFT = 3'h1, M_EXT = 3'h2, M_PERIOD = 3'h3
  } qmode_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_CONV = 2'b01, S_FROZEN = 2'b11, S_STOPPED = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic start;
    logic analogRst;
    logic clkTick;
    logic [5:0] channel;
    logic [1:0] group;
  } afe_req_t;

  typedef struct packed {
    logic done;
    logic [9:0] result;
  } afe_rsp_t;
endpackage

// [rtl/queued_converter_ctrl.sv]
/*
 * Digital control shell of the queued converter: APB register slave,
 * port pins, external mux addressing, stop, freeze and access protection.
 * Assumes pins synchronous to ref_clk and an analog front end that pulses
 * done once per started conversion.
 */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module queued_converter_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int RECOVERY = RECOVERY_CYCLES,
  parameter int PERIOD = PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic refClk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus freeze line
  input wire logic freezeIn,
  // Ports
  input wire logic [7:0] inputPortPins,
  input wire logic [7:0] bidirPinIn,
  output logic [7:0] bidirPinOut,
  output logic [7:0] bidirPinOe,
  // Analog front end
  output afe_req_t afeReq,
  input wire afe_rsp_t afeRsp
);
  // ********************************
  // State
  // ********************************
  logic [15:0] mcr_q, test_q, intr_q, cr0_q, q1_q, q2_q;
  logic [7:0] paData_q, paDir_q;
  logic [9:0] ccw_q [TABLE_WORDS];
  logic [9:0] res_q [TABLE_WORDS];
  seq_state_t state_q;
  logic [5:0] ptr_q, savedPtr_q;
  logic running_q, actQ2_q, q1Done_q, q2Done_q, trig1_q, trig2_q;
  logic [1:0] trigPrev_q;
  logic [15:0] recCnt_q, tmr_q;
  logic [4:0] divCnt_q;
  logic [MA_W-1:0] muxAddr_q;
  logic [2:0] waitCnt_q;
  afe_req_t afeReq_q;
  logic [7:0] paOe_q;

  logic stop, frzReq, muxEn, supervisor_select_bit, priv, setup, wrEn, isTable, superOnly;
  logic tblBusy, conflict, issue, unmapped, periodTick, divTick;
  logic modeChg1, modeChg2, abortQ2, killActive;
  logic [2:0] mode1, mode2;
  logic [5:0] idx, bq2, chan, endPtr;
  logic [15:0] rdVal, wMask, wData;
  logic [7:0] paRead, paOeD;

  assign stop = mcr_q[MCR_STOP_BIT];
  assign frzReq = freezeIn & mcr_q[MCR_FRZ_BIT]; // [R12]
  assign muxEn = cr0_q[CR0_MUX_BIT]; // [R22]
  assign supervisor_select_bit = mcr_q[MCR_SUPERVISOR_SELECT_BIT_BIT];
  assign priv = pprot[0];
  assign mode1 = q1_q[QCR_MODE_LSB +: 3];
  assign mode2 = q2_q[QCR_MODE_LSB +: 3];
  assign bq2 = q2_q[QCR_BQ2_LSB +: 6];
  assign idx = paddr[7:2];
  assign chan = ccw_q[ptr_q][5:0];
  assign endPtr = actQ2_q ? 6'(TABLE_WORDS) : bq2;
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pready & pwrite;
  assign isTable = (paddr[11:8] == CCW_PAGE) || (paddr[11:8] == RES_PAGE);
  assign superOnly = (paddr == MCR_OFF) || (paddr == TEST_OFF) || (paddr == INTR_OFF); // [R18]

  // ********************************
  // APB timing and wait states
  // ********************************
  // The sequencer owns the table port while fetching a word or storing a
  // result; a colliding bus access waits, but never more than four cycles.
  assign tblBusy = (state_q == S_IDLE && running_q && !stop) || (state_q == S_CONV && afeRsp.done);
  assign conflict = isTable & tblBusy;
  assign issue = psel & ~pready & (~conflict | (waitCnt_q == 3'(MAX_WAIT))); // [R07]

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      waitCnt_q <= '0;
    end else begin
      pready <= issue;
      if (issue) begin
        prdata <= {16'h0000, rdVal}; // [R06]
        pslverr <= unmapped;
        waitCnt_q <= '0;
      end else if (psel && !pready) begin
        waitCnt_q <= waitCnt_q + 3'd1; // [R07]
      end
    end
  end

  // ********************************
  // Read decode and protection
  // ********************************
  always_comb begin
    rdVal = 16'h0000;
    unmapped = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      unmapped = 1'b1;
    end else if (paddr[11:8] == CCW_PAGE || paddr[11:8] == RES_PAGE) begin
      if (idx >= 6'(TABLE_WORDS)) begin
        unmapped = 1'b1;
      end else if (!stop) begin // [R11]
        rdVal = {6'h00, (paddr[11:8] == CCW_PAGE) ? ccw_q[idx] : res_q[idx]};
      end
    end else if (paddr[11:8] != 4'h0) begin
      unmapped = 1'b1;
    end else begin
      case (paddr)
        MCR_OFF: rdVal = mcr_q & MCR_MASK; // [R08]
        TEST_OFF: rdVal = test_q;
        INTR_OFF: rdVal = intr_q;
        PA_OFF: rdVal = {8'h00, paRead};
        PB_OFF: rdVal = {8'h00, inputPortPins}; // [R01]
        DIR_OFF: rdVal = {8'h00, paDir_q};
        CR0_OFF: rdVal = cr0_q;
        Q1_OFF: rdVal = q1_q;
        Q2_OFF: rdVal = q2_q;
        STAT_OFF: rdVal = {2'b00, actQ2_q, (recCnt_q != 16'h0000), trig2_q, trig1_q,
                           q2Done_q, q1Done_q, state_q, ptr_q};
        default: unmapped = 1'b1;
      endcase
    end
    if (!priv && superOnly) begin
      rdVal = 16'h0000; // [R19]
    end else if (!priv && supervisor_select_bit && !unmapped) begin
      rdVal = 16'hffff; // [R20]
    end
  end

  // ********************************
  // Register writes
  // ********************************
  logic wrOk;
  assign wMask = {{8{pstrb[1]}}, {8{pstrb[0]}}}; // [R06]
  assign wData = pwdata[15:0];
  assign wrOk = wrEn & (priv | (~superOnly & ~supervisor_select_bit)); // [R21]
  assign modeChg1 = wrOk & ~stop & (paddr == Q1_OFF) & pstrb[1] & (wData[10:8] != mode1);
  assign modeChg2 = wrOk & ~stop & (paddr == Q2_OFF) & pstrb[1] & (wData[10:8] != mode2);
  assign abortQ2 = wrOk & ~stop & (paddr == Q2_OFF) & pstrb[1] & wData[QCR_ABORT_BIT];
  assign killActive = running_q & (actQ2_q ? (modeChg2 | abortQ2) : modeChg1);

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      mcr_q <= MCR_RESET;
      test_q <= '0;
      intr_q <= '0;
    end else if (wrOk) begin // [R10]
      case (paddr)
        MCR_OFF: mcr_q <= ((mcr_q & ~wMask) | (wData & wMask)) & MCR_MASK; // [R08]
        TEST_OFF: test_q <= (test_q & ~wMask) | (wData & wMask);
        INTR_OFF: intr_q <= (intr_q & ~wMask) | (wData & wMask);
        default: ;
      endcase
    end
  end

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      paData_q <= '0;
      paDir_q <= '0;
    end else if (wrOk && !stop && pstrb[0]) begin // [R10]
      if (paddr == PA_OFF) begin
        paData_q <= wData[7:0];
      end
      if (paddr == DIR_OFF) begin
        paDir_q <= wData[7:0];
      end
    end
  end

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      cr0_q <= CTRL_RESET;
      q1_q <= CTRL_RESET;
      q2_q <= CTRL_RESET;
    end else if (stop) begin // [R10]
      cr0_q <= CTRL_RESET;
      q1_q <= CTRL_RESET;
      q2_q <= CTRL_RESET;
    end else if (wrOk) begin
      case (paddr)
        CR0_OFF: cr0_q <= ((cr0_q & ~wMask) | (wData & wMask)) & CR0_MASK;
        Q1_OFF: q1_q <= ((q1_q & ~wMask) | (wData & wMask)) & Q1_MASK;
        Q2_OFF: q2_q <= ((q2_q & ~wMask) | (wData & wMask)) & Q2_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge refClk) begin
    if (wrOk && !stop && paddr[11:8] == CCW_PAGE && idx < 6'(TABLE_WORDS)) begin // [R16]
      ccw_q[idx] <= {pstrb[1] ? wData[9:8] : ccw_q[idx][9:8],
                     pstrb[0] ? wData[7:0] : ccw_q[idx][7:0]};
    end
  end

  // ********************************
  // Divider, periodic timer, recovery
  // ********************************
  assign divTick = (divCnt_q == cr0_q[CR0_PRESC_LSB +: 5]);
  assign periodTick = (tmr_q == 16'(PERIOD - 1));

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      divCnt_q <= '0;
    end else if (stop || divTick) begin
      divCnt_q <= '0; // [R11] [R15]
    end else begin
      divCnt_q <= divCnt_q + 5'd1;
    end
  end

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      tmr_q <= '0;
    end else if (stop || state_q == S_FROZEN || periodTick) begin
      tmr_q <= '0; // [R11] [R15]
    end else begin
      tmr_q <= tmr_q + 16'd1;
    end
  end

  // Conversions stay blocked until the analog bias has settled
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      recCnt_q <= '0;
    end else if (stop) begin
      recCnt_q <= 16'(RECOVERY); // [R09]
    end else if (recCnt_q != 16'h0000) begin
      recCnt_q <= recCnt_q - 16'd1;
    end
  end

  // ********************************
  // Trigger capture
  // ********************************
  // A new trigger that lands with the clearing completion is kept.
  logic clr1, clr2, rec;
  assign clr1 = running_q & ~actQ2_q & (state_q == S_IDLE) & (chan == END_CHAN || ptr_q == endPtr);
  assign clr2 = running_q & actQ2_q & (state_q == S_IDLE) & (chan == END_CHAN || ptr_q == endPtr);
  assign rec = (state_q != S_FROZEN) & ~stop; // [R16]

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      trigPrev_q <= 2'b11; // Pins idle high, so reset makes no false edge
      trig1_q <= 1'b0;
      trig2_q <= 1'b0;
    end else begin
      trigPrev_q <= {bidirPinIn[TRIG2_PIN], bidirPinIn[TRIG1_PIN]};
      if (stop || modeChg1) begin
        trig1_q <= 1'b0;
      end else if (rec && ((mode1 == M_EXT && bidirPinIn[TRIG1_PIN] && !trigPrev_q[0])
          || (mode1 == M_PERIOD && periodTick)
          || (mode1 == M_SOFT && wrOk && paddr == Q1_OFF && wData[QCR_SWTRIG_BIT]))) begin
        trig1_q <= 1'b1; // [R02]
      end else if (clr1) begin
        trig1_q <= 1'b0;
      end
      if (stop || modeChg2 || abortQ2) begin
        trig2_q <= 1'b0;
      end else if (rec && ((mode2 == M_EXT && bidirPinIn[TRIG2_PIN] && !trigPrev_q[1])
          || (mode2 == M_PERIOD && periodTick)
          || (mode2 == M_SOFT && wrOk && paddr == Q2_OFF && wData[QCR_SWTRIG_BIT]))) begin
        trig2_q <= 1'b1; // [R02]
      end else if (clr2) begin
        trig2_q <= 1'b0;
      end
    end
  end

  // ********************************
  // Conversion sequencer
  // ********************************
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      state_q <= S_IDLE;
      ptr_q <= '0;
      savedPtr_q <= '0;
      running_q <= 1'b0;
      actQ2_q <= 1'b0;
      muxAddr_q <= '0;
      afeReq_q <= '0;
    end else begin
      afeReq_q.start <= 1'b0;
      afeReq_q.clkTick <= divTick & ~stop & (state_q != S_FROZEN); // [R09] [R15]
      afeReq_q.analogRst <= stop | (state_q == S_FROZEN); // [R15]
      if (killActive) begin
        running_q <= 1'b0; // [R17]
      end
      if (stop) begin
        state_q <= S_STOPPED; // [R09]
        running_q <= 1'b0;
      end else begin
        case (state_q)
          S_STOPPED: begin
            state_q <= S_IDLE;
          end
          S_FROZEN: begin
            if (!frzReq) begin
              state_q <= S_IDLE;
              ptr_q <= savedPtr_q; // [R17]
            end
          end
          S_IDLE: begin
            if (frzReq) begin
              state_q <= S_FROZEN; // [R13]
              savedPtr_q <= ptr_q; // [R14]
            end else if (running_q && !killActive) begin
              if (chan == END_CHAN || ptr_q == endPtr) begin
                running_q <= 1'b0;
              end else if (recCnt_q == 16'h0000) begin
                state_q <= S_CONV;
                afeReq_q.start <= 1'b1;
                afeReq_q.channel <= chan;
                afeReq_q.group <= {chan[4], chan[0]}; // [R05]
                if (muxEn && chan < 6'd32) begin
                  muxAddr_q <= chan[3:1]; // [R03]
                end
              end
            end else if (mode1 != M_OFF && trig1_q) begin
              running_q <= 1'b1; // [R17]
              actQ2_q <= 1'b0;
              ptr_q <= '0;
            end else if (mode2 != M_OFF && trig2_q) begin
              running_q <= 1'b1;
              actQ2_q <= 1'b1;
              ptr_q <= bq2;
            end
          end
          S_CONV: begin
            if (killActive) begin
              state_q <= frzReq ? S_FROZEN : S_IDLE; // [R13]
              savedPtr_q <= ptr_q;
            end else if (afeRsp.done) begin
              ptr_q <= ptr_q + 6'd1;
              savedPtr_q <= ptr_q + 6'd1; // [R14]
              state_q <= frzReq ? S_FROZEN : S_IDLE; // [R13]
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge refClk) begin
    if (state_q == S_CONV && afeRsp.done && !killActive && !stop) begin
      res_q[ptr_q] <= afeRsp.result;
    end
  end

  // Completion flags: software clears with a one; a new completion wins
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      q1Done_q <= 1'b0;
      q2Done_q <= 1'b0;
    end else if (stop) begin
      q1Done_q <= 1'b0; // [R10]
      q2Done_q <= 1'b0;
    end else begin
      q1Done_q <= clr1 | (q1Done_q & ~(wrOk && paddr == STAT_OFF && pstrb[1] && wData[8]));
      q2Done_q <= clr2 | (q2Done_q & ~(wrOk && paddr == STAT_OFF && pstrb[1] && wData[9]));
    end
  end

  // ********************************
  // Port A pins
  // ********************************
  // Pins are open drain: they only ever pull low, so the output is zero
  // and the enable carries the data.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      paOeD[i] = paDir_q[i] & ~paData_q[i];
      paRead[i] = paDir_q[i] ? paData_q[i] : bidirPinIn[i];
      if (muxEn && i < MA_W) begin
        paOeD[i] = ~muxAddr_q[i % MA_W]; // [R04]
        paRead[i] = muxAddr_q[i % MA_W]; // [R23]
      end
      if ((i == TRIG1_PIN && mode1 == M_EXT) || (i == TRIG2_PIN && mode2 == M_EXT)) begin
        paOeD[i] = 1'b0; // [R02]
        paRead[i] = bidirPinIn[i];
      end
    end
  end

  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      paOe_q <= '0;
      bidirPinOut <= '0;
    end else begin
      paOe_q <= paOeD;
      bidirPinOut <= '0;
    end
  end

  assign bidirPinOe = paOe_q;
  assign afeReq = afeReq_q;

  // ********************************
  // Assertions
  // ********************************
  a_port_b_read: assert property (@(posedge refClk) disable iff (reset) // [R01]
    (setup && priv && paddr == PB_OFF && !conflict) |=> prdata[7:0] == $past(inputPortPins))
    else $error("port B read value wrong");
  a_trig_pin_input: assert property (@(posedge refClk) disable iff (reset) // [R02]
    (mode1 == M_EXT) |=> !bidirPinOe[TRIG1_PIN])
    else $error("trigger pin driven");
  a_mux_pins_out: assert property (@(posedge refClk) disable iff (reset) // [R04]
    muxEn |=> bidirPinOe[2:0] == ~$past(muxAddr_q))
    else $error("mux address pins wrong");
  a_group_select: assert property (@(posedge refClk) disable iff (reset) // [R05]
    afeReq.start |-> afeReq.group == {afeReq.channel[4], afeReq.channel[0]})
    else $error("group select wrong");
  a_ready_two: assert property (@(posedge refClk) disable iff (reset) // [R07]
    (setup && !pready && !conflict) |=> pready)
    else $error("no two-cycle answer");
  a_wait_bound: assert property (@(posedge refClk) disable iff (reset) // [R07]
    (setup && !pready) |-> ##[1:5] pready)
    else $error("too many wait states");
  a_user_zero: assert property (@(posedge refClk) disable iff (reset) // [R19]
    (setup && !priv && superOnly && !conflict) |=> prdata == 32'h0000_0000)
    else $error("user read of global space not zero");
  a_user_ones: assert property (@(posedge refClk) disable iff (reset) // [R20]
    (setup && !priv && supervisor_select_bit && !superOnly && !unmapped && !conflict) |=> prdata == 32'h0000_ffff)
    else $error("user read of assigned space not ffff");
  a_stop_clock: assert property (@(posedge refClk) disable iff (reset) // [R09]
    stop [*2] |-> !afeReq.clkTick && state_q == S_STOPPED)
    else $error("converter clock runs in stop");
  a_freeze_idle: assert property (@(posedge refClk) disable iff (reset) // [R13]
    (state_q == S_IDLE && frzReq && !stop) |=> state_q == S_FROZEN ##1 afeReq.analogRst)
    else $error("idle freeze not immediate");
endmodule

// [bench/afe_stub.sv]
/*
 * Behavioural analog front end for the converter shell bench.
 * Assumes start pulses from afeReq on refClk; answers done after 4 cycles.
 */
`timescale 1ns/1ns
module afe_stub
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic refClk,
  input wire logic reset,
  // Shell side
  input wire afe_req_t afeReq,
  output afe_rsp_t afeRsp
);
  logic [2:0] busyQ;
  // Result is only meaningful with done, so it toggles otherwise
  always_ff @(posedge refClk or posedge reset) begin
    if (reset) begin
      busyQ <= 3'h0;
      afeRsp <= '0;
    end else begin
      afeRsp.done <= (busyQ == 3'h1);
      afeRsp.result <= (busyQ == 3'h1) ? {afeReq.channel, 4'h5} : ~afeRsp.result;
      if (afeReq.analogRst) begin
        busyQ <= 3'h0;
      end else if (afeReq.start) begin
        busyQ <= 3'h4;
      end else if (busyQ != 3'h0) begin
        busyQ <= busyQ - 3'h1;
      end
    end
  end
endmodule

// [bench/adc_module_config_and_pin_control_tb.sv]
/*
 * Self-checking bench for queued_converter_ctrl over APB.
 * Assumes port A has external pull-ups; the front end is afe_stub.
 */
`timescale 1ns/1ns
module adc_module_config_and_pin_control_tb;
  import adc_ctrl_pkg::*;
  logic refClk, reset, psel, penable, pwrite, freezeIn, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  logic [7:0] inputPortPins, bidirPinIn, bidirPinOut, bidirPinOe;
  afe_req_t afeReq;
  afe_rsp_t afeRsp;
  int badCount, testsRun, cycles, waits;
  // Open drain: a pin reads low only while someone pulls it
  assign bidirPinIn = ~bidirPinOe;

  queued_converter_ctrl #(.RECOVERY(4), .PERIOD(16)) i_dut (
    .refClk(refClk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freezeIn(freezeIn), .inputPortPins(inputPortPins), .bidirPinIn(bidirPinIn),
    .bidirPinOut(bidirPinOut), .bidirPinOe(bidirPinOe), .afeReq(afeReq),
    .afeRsp(afeRsp));
  afe_stub i_afe (.refClk(refClk), .reset(reset), .afeReq(afeReq), .afeRsp(afeRsp));

  initial begin
    refClk = 0;
    forever #50 refClk = ~refClk;
  end

  task automatic endOfTest();
    $display("compares=%0d mismatches=%0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge refClk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      endOfTest();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ********************************
  // APB master
  // ********************************
  task automatic apb(input logic wr, input logic sup, input logic [11:0] a,
                     input logic [31:0] d);
    waits = 0;
    @(posedge refClk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot <= {2'b00, sup};
    @(posedge refClk);
    penable <= 1'b1;
    do begin
      @(posedge refClk);
      waits++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, 1'b1, a, d);
    chk(waits, 1);
  endtask

  task automatic rdc(input logic [11:0] a, input logic sup, input logic [31:0] exp);
    apb(1'b0, sup, a, 32'h0);
    chk(rd, exp);
    chk(err, 1'b0);
    chk(waits, 1);
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic tConfig();
    rdc(MCR_OFF, 1'b1, 32'h0000_0080);
    wr(MCR_OFF, 32'h0000_ffff);
    rdc(MCR_OFF, 1'b1, 32'h0000_c08f);
    apb(1'b0, 1'b1, 12'h002, 32'h0);
    chk(err, 1'b1);
    wr(MCR_OFF, 32'h0000_0080);
  endtask

  task automatic tPortB();
    inputPortPins <= 8'ha5;
    rdc(PB_OFF, 1'b1, 32'h0000_00a5);
    inputPortPins <= 8'h3c;
    rdc(PB_OFF, 1'b0, 32'h0000_ffff);
  endtask

  task automatic tSuper();
    rdc(MCR_OFF, 1'b0, 32'h0);
    apb(1'b1, 1'b0, MCR_OFF, 32'h0);
    rdc(MCR_OFF, 1'b1, 32'h0000_0080);
    apb(1'b1, 1'b0, CR0_OFF, 32'h0000_0003);
    rdc(CR0_OFF, 1'b1, 32'h0);
    wr(MCR_OFF, 32'h0);
    apb(1'b1, 1'b0, CR0_OFF, 32'h0000_0003);
    rdc(CR0_OFF, 1'b0, 32'h0000_0003);
    apb(1'b1, 1'b0, TEST_OFF, 32'h0000_0001);
    rdc(TEST_OFF, 1'b1, 32'h0);
    wr(CR0_OFF, 32'h0);
    wr(MCR_OFF, 32'h0000_0080);
  endtask

  task automatic tPins();
    wr(DIR_OFF, 32'h0000_0018);
    wr(PA_OFF, 32'h0);
    wr(CR0_OFF, 32'h0000_8000);
    repeat (2) @(posedge refClk);
    chk(bidirPinOe, 8'h1f);
    chk(bidirPinOut, 8'h00);
    rdc(PA_OFF, 1'b1, 32'h0000_00e0);
    wr(Q1_OFF, 32'h0000_0200);
    repeat (2) @(posedge refClk);
    chk(bidirPinOe, 8'h17);
    wr(CR0_OFF, 32'h0);
    wr(Q1_OFF, 32'h0);
    repeat (2) @(posedge refClk);
    chk(bidirPinOe, 8'h18);
  endtask

  task automatic tStop();
    wr(CR0_OFF, 32'h0000_0005);
    wr(MCR_OFF, 32'h0000_8080);
    wr(DIR_OFF, 32'h0);
    rdc(DIR_OFF, 1'b1, 32'h0000_0018);
    rdc(CR0_OFF, 1'b1, 32'h0);
    rdc(MCR_OFF, 1'b1, 32'h0000_8080);
    rdc(CCW_PAGE * 12'h100, 1'b1, 32'h0);
    wr(MCR_OFF, 32'h0000_0080);
    wr(DIR_OFF, 32'h0);
  endtask

  task automatic tFreeze();
    freezeIn <= 1'b1;
    repeat (20) @(posedge refClk);
    apb(1'b0, 1'b1, STAT_OFF, 32'h0);
    chk(rd[7:6], 2'b00);
    wr(MCR_OFF, 32'h0000_4080);
    repeat (4) @(posedge refClk);
    apb(1'b0, 1'b1, STAT_OFF, 32'h0);
    chk(rd[7:6], 2'b11);
    freezeIn <= 1'b0;
    wr(MCR_OFF, 32'h0000_0080);
    repeat (4) @(posedge refClk);
    apb(1'b0, 1'b1, STAT_OFF, 32'h0);
    chk(rd[7:6], 2'b00);
  endtask

  // Queue 1 converts words 0 and 1, then reruns, is frozen once word 0 completes and resumed
  task automatic tConvert();
    wr(CCW_PAGE * 12'h100, 32'h0000_0005);
    wr(CCW_PAGE * 12'h100 + 12'h004, 32'h0000_0016);
    wr(Q2_OFF, 32'h0000_0002);
    wr(CR0_OFF, 32'h0000_8000);
    wr(Q1_OFF, 32'h0000_0100);
    wr(Q1_OFF, 32'h0000_2100);
    repeat (30) @(posedge refClk);
    rdc(RES_PAGE * 12'h100, 1'b1, 32'h0000_0055);
    rdc(RES_PAGE * 12'h100 + 12'h004, 1'b1, 32'h0000_0165);
    rdc(PA_OFF, 1'b1, 32'h0000_00fb);
    chk(bidirPinOe, 8'h04);
    rdc(STAT_OFF, 1'b1, 32'h0000_0102);
    wr(MCR_OFF, 32'h0000_4080);
    wr(Q1_OFF, 32'h0000_2100);
    repeat (3) @(posedge refClk);
    freezeIn <= 1'b1;
    repeat (10) @(posedge refClk);
    rdc(STAT_OFF, 1'b1, 32'h0000_05c1);
    freezeIn <= 1'b0;
    repeat (20) @(posedge refClk);
    rdc(STAT_OFF, 1'b1, 32'h0000_0102);
    wr(MCR_OFF, 32'h0000_0080);
  endtask

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, freezeIn} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h3;
    pprot = 3'h1;
    inputPortPins = 8'h0;
    repeat (4) @(posedge refClk);
    reset <= 1'b0;
    tConfig();
    tPortB();
    tSuper();
    tPins();
    tStop();
    tFreeze();
    tConvert();
    endOfTest();
  end
endmodule
